// ==== logic/seicmd_pkg.sv ====
// Constants shared by the seismic command termination logic.
// Assumes one 10 MHz clock and an APB slave of 32-bit aligned words.
package seicmd_pkg;

  localparam int NUM_LINES = 15;

  // Command line positions on the incoming pulse vector.
  localparam int LINE_UNCAGE = 0;
  localparam int LINE_FILTER = 1;
  localparam int LINE_LEVEL_MODE = 2;
  localparam int LINE_LEVEL_SPEED = 3;
  localparam int LINE_LEVEL_DIR = 4;
  localparam int LINE_COARSE = 5;
  localparam int LINE_MOTOR_X = 6;
  localparam int LINE_MOTOR_Y = 7;
  localparam int LINE_MOTOR_Z = 8;
  localparam int LINE_GAIN_H = 9;
  localparam int LINE_GAIN_V = 10;
  localparam int LINE_GAIN_SP = 11;
  localparam int LINE_CAL_LP = 12;
  localparam int LINE_CAL_SP = 13;
  localparam int LINE_HEATER = 14;

  // APB byte addresses.
  localparam logic [7:0] ADDR_STATE = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_SWCMD = 8'h08;

  localparam logic [14:0] MASK_RESET = 15'h7fff;

  // Preset values; gain index 3 is the -30 dB signal step.
  localparam logic [1:0] GAIN_PRESET = 2'h3;
  localparam logic [1:0] HEAT_PRESET = 2'h0;
  localparam logic TOGGLE_PRESET = 1'h0;

  // Field positions in the state word.
  localparam int ST_GAIN_H = 0;
  localparam int ST_GAIN_V = 2;
  localparam int ST_GAIN_SP = 4;
  localparam int ST_HEAT = 6;
  localparam int ST_ARMED = 8;
  localparam int ST_UNCAGED = 9;
  localparam int ST_FILTER = 10;
  localparam int ST_MODE = 11;
  localparam int ST_SPEED = 12;
  localparam int ST_DIR = 13;
  localparam int ST_COARSE = 14;
  localparam int ST_MOTOR_X = 15;
  localparam int ST_MOTOR_Y = 16;
  localparam int ST_MOTOR_Z = 17;
  localparam int ST_CAL_LP = 18;
  localparam int ST_CAL_SP = 19;

endpackage

// ==== logic/seicmd_sync.sv ====
// Two-stage synchroniser and rising-edge detector for command pulse pins.
// Assumes the pins are asynchronous to pclk and stay high at least two cycles.
`timescale 1ns/1ps
`default_nettype none
module seicmd_sync
  import seicmd_pkg::*;
#(
  parameter int W = NUM_LINES
)
(
  input wire logic pclk, // system clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic [W-1:0] async_in, // raw command pins
  output logic [W-1:0] rise // one-cycle pulse per pin rising edge
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } seicmd_sync_s;

  seicmd_sync_s r;
  seicmd_sync_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else
      r <= next_r;
  end

  // The edge detector compares the second stage with the third, so a long pulse steps once.
  assign rise = r.s2 & ~r.s3;

endmodule
`default_nettype wire

// ==== logic/seicmd_core.sv ====
// Command termination logic: fifteen command lines end in toggles, counters or the arm-then-fire uncage sequence.
// Assumes a 10 MHz pclk, asynchronous pins for the command lines and an APB master.
`timescale 1ns/1ps
`default_nettype none
module seicmd_core
  import seicmd_pkg::*;
(
  input wire logic pclk, // system clock, 10 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  input wire logic [14:0] cmd_pulse, // command decoder pulse lines
  output logic [1:0] att_h_sig, // horizontal signal attenuator step
  output logic [1:0] att_h_cal, // horizontal calibration attenuator step
  output logic [1:0] att_v_sig, // vertical signal attenuator step
  output logic [1:0] att_v_cal, // vertical calibration attenuator step
  output logic [1:0] att_sp_sig, // short-period signal attenuator step
  output logic [1:0] att_sp_cal, // short-period calibration attenuator step
  output logic [1:0] heater_relay, // heater relay select
  output logic filter_in, // feedback filters in, bypass open
  output logic level_cmd_mode, // leveling in command mode
  output logic level_speed_high, // high leveling speed
  output logic level_dir_neg, // negative leveling direction
  output logic coarse_sensor_on, // coarse leveling sensor power
  output logic motor_x_on, // X leveling motor power
  output logic motor_y_on, // Y leveling motor power
  output logic motor_z_on, // Z leveling motor power
  output logic cal_lp_on, // long-period calibration power
  output logic cal_sp_on, // short-period calibration power
  output logic uncage_armed, // uncaging armed
  output logic uncage_fire, // one-cycle uncaging actuator pulse
  output logic uncaged // uncaging has been fired
);

  typedef struct packed {
    logic por_done;
    logic [14:0] mask;
    logic [14:0] sw_pulse;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] gain_h;
    logic [1:0] gain_h_cal;
    logic [1:0] gain_v;
    logic [1:0] gain_v_cal;
    logic [1:0] gain_sp;
    logic [1:0] gain_sp_cal;
    logic [1:0] heat;
    logic armed;
    logic uncaged;
    logic uncage_fire;
    logic filter_in;
    logic mode_cmd;
    logic speed_high;
    logic dir_neg;
    logic speed_eff;
    logic dir_eff;
    logic coarse;
    logic mot_x;
    logic mot_y;
    logic mot_z;
    logic cal_lp;
    logic cal_sp;
  } seicmd_state_s;

  localparam seicmd_state_s STATE_RST = '{
    mask: MASK_RESET,
    gain_h: GAIN_PRESET,
    gain_h_cal: ~GAIN_PRESET,
    gain_v: GAIN_PRESET,
    gain_v_cal: ~GAIN_PRESET,
    gain_sp: GAIN_PRESET,
    gain_sp_cal: ~GAIN_PRESET,
    heat: HEAT_PRESET,
    armed: TOGGLE_PRESET,
    uncaged: TOGGLE_PRESET,
    filter_in: TOGGLE_PRESET,
    mode_cmd: TOGGLE_PRESET,
    speed_high: TOGGLE_PRESET,
    dir_neg: TOGGLE_PRESET,
    coarse: TOGGLE_PRESET,
    mot_x: TOGGLE_PRESET,
    mot_y: TOGGLE_PRESET,
    mot_z: TOGGLE_PRESET,
    cal_lp: TOGGLE_PRESET,
    cal_sp: TOGGLE_PRESET,
    default: '0
  };

  seicmd_state_s r;
  seicmd_state_s next_r;
  logic [14:0] pin_rise;
  logic [14:0] fire;
  logic preset;
  logic access;

  ////////////////////////////////////////////////////////////////////////////
  // Command pins.

  seicmd_sync #(.W(NUM_LINES)) u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(cmd_pulse),
    .rise(pin_rise)
  );

  // The counters are two serial stages; a plain increment gives the same order.
  function automatic logic [1:0] step2(input logic [1:0] cur);
    step2 = cur + 2'h1;
  endfunction

  function automatic logic [31:0] state_word(input seicmd_state_s s);
    state_word = '0;
    state_word[ST_GAIN_H +: 2] = s.gain_h;
    state_word[ST_GAIN_V +: 2] = s.gain_v;
    state_word[ST_GAIN_SP +: 2] = s.gain_sp;
    state_word[ST_HEAT +: 2] = s.heat;
    state_word[ST_ARMED] = s.armed;
    state_word[ST_UNCAGED] = s.uncaged;
    state_word[ST_FILTER] = s.filter_in;
    state_word[ST_MODE] = s.mode_cmd;
    state_word[ST_SPEED] = s.speed_high;
    state_word[ST_DIR] = s.dir_neg;
    state_word[ST_COARSE] = s.coarse;
    state_word[ST_MOTOR_X] = s.mot_x;
    state_word[ST_MOTOR_Y] = s.mot_y;
    state_word[ST_MOTOR_Z] = s.mot_z;
    state_word[ST_CAL_LP] = s.cal_lp;
    state_word[ST_CAL_SP] = s.cal_sp;
  endfunction

  // Pin and software pulses merge, so software can exercise every line too.
  assign fire = (pin_rise | r.sw_pulse) & r.mask;
  // The first cycle after reset release acts as the power-on one-shot.
  assign preset = ~r.por_done;
  assign access = psel & penable & r.pready;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    next_r = r;
    next_r.por_done = 1'h1;
    next_r.sw_pulse = '0;
    next_r.uncage_fire = 1'h0;

    // APB: answer in the first access cycle, with no wait states.
    next_r.pready = psel & ~penable;
    next_r.pslverr = 1'h0;
    next_r.prdata = '0;
    if (psel && !penable)
    begin
      case (paddr)
        ADDR_STATE: next_r.prdata = pwrite ? 32'h0 : state_word(r);
        ADDR_MASK: next_r.prdata = pwrite ? 32'h0 : {17'h0, r.mask};
        ADDR_SWCMD: next_r.prdata = 32'h0;
        default: next_r.pslverr = 1'h1;
      endcase
    end
    if (access && pwrite)
    begin
      case (paddr)
        ADDR_MASK: next_r.mask = pwdata[14:0];
        ADDR_SWCMD: next_r.sw_pulse = pwdata[14:0];
        default: next_r.mask = r.mask;
      endcase
    end

    // Each line touches only its own element.
    if (fire[LINE_UNCAGE])
    begin
      if (r.armed)
      begin
        next_r.uncage_fire = 1'h1;
        next_r.uncaged = 1'h1;
        next_r.armed = 1'h0;
      end
      else if (!r.uncaged)
        next_r.armed = 1'h1;
    end
    if (fire[LINE_FILTER])
      next_r.filter_in = ~r.filter_in;
    if (fire[LINE_LEVEL_MODE])
      next_r.mode_cmd = ~r.mode_cmd;
    if (fire[LINE_LEVEL_SPEED])
      next_r.speed_high = ~r.speed_high;
    if (fire[LINE_LEVEL_DIR])
      next_r.dir_neg = ~r.dir_neg;
    if (fire[LINE_COARSE])
      next_r.coarse = ~r.coarse;
    if (fire[LINE_MOTOR_X])
      next_r.mot_x = ~r.mot_x;
    if (fire[LINE_MOTOR_Y])
      next_r.mot_y = ~r.mot_y;
    if (fire[LINE_MOTOR_Z])
      next_r.mot_z = ~r.mot_z;
    if (fire[LINE_CAL_LP])
      next_r.cal_lp = ~r.cal_lp;
    if (fire[LINE_CAL_SP])
      next_r.cal_sp = ~r.cal_sp;
    if (fire[LINE_GAIN_H])
      next_r.gain_h = step2(r.gain_h);
    if (fire[LINE_GAIN_V])
      next_r.gain_v = step2(r.gain_v);
    if (fire[LINE_GAIN_SP])
      next_r.gain_sp = step2(r.gain_sp);
    if (fire[LINE_HEATER])
      next_r.heat = step2(r.heat);

    // The preset outranks any pulse caught in the same cycle.
    if (preset)
    begin
      next_r.gain_h = STATE_RST.gain_h;
      next_r.gain_v = STATE_RST.gain_v;
      next_r.gain_sp = STATE_RST.gain_sp;
      next_r.heat = STATE_RST.heat;
      next_r.armed = STATE_RST.armed;
      next_r.uncaged = STATE_RST.uncaged;
      next_r.uncage_fire = 1'h0;
      next_r.filter_in = STATE_RST.filter_in;
      next_r.mode_cmd = STATE_RST.mode_cmd;
      next_r.speed_high = STATE_RST.speed_high;
      next_r.dir_neg = STATE_RST.dir_neg;
      next_r.coarse = STATE_RST.coarse;
      next_r.mot_x = STATE_RST.mot_x;
      next_r.mot_y = STATE_RST.mot_y;
      next_r.mot_z = STATE_RST.mot_z;
      next_r.cal_lp = STATE_RST.cal_lp;
      next_r.cal_sp = STATE_RST.cal_sp;
    end

    // Calibration steps run opposite to the signal steps.
    next_r.gain_h_cal = ~next_r.gain_h;
    next_r.gain_v_cal = ~next_r.gain_v;
    next_r.gain_sp_cal = ~next_r.gain_sp;
    // Speed and direction only reach the servos in command mode.
    next_r.speed_eff = next_r.speed_high & next_r.mode_cmd;
    next_r.dir_eff = next_r.dir_neg & next_r.mode_cmd;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= STATE_RST;
    else
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register.

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign att_h_sig = r.gain_h;
  assign att_h_cal = r.gain_h_cal;
  assign att_v_sig = r.gain_v;
  assign att_v_cal = r.gain_v_cal;
  assign att_sp_sig = r.gain_sp;
  assign att_sp_cal = r.gain_sp_cal;
  assign heater_relay = r.heat;
  assign filter_in = r.filter_in;
  assign level_cmd_mode = r.mode_cmd;
  assign level_speed_high = r.speed_eff;
  assign level_dir_neg = r.dir_eff;
  assign coarse_sensor_on = r.coarse;
  assign motor_x_on = r.mot_x;
  assign motor_y_on = r.mot_y;
  assign motor_z_on = r.mot_z;
  assign cal_lp_on = r.cal_lp;
  assign cal_sp_on = r.cal_sp;
  assign uncage_armed = r.armed;
  assign uncage_fire = r.uncage_fire;
  assign uncaged = r.uncaged;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_gain_h_step;
    fire[LINE_GAIN_H] && !preset |=> att_h_sig == $past(att_h_sig) + 2'h1;
  endproperty
  a_gain_h_step: assert property (p_gain_h_step) else $error("gain step missed");

  property p_cal_reverse;
    ##1 (att_h_cal == ~att_h_sig) && (att_v_cal == ~att_v_sig) && (att_sp_cal == ~att_sp_sig);
  endproperty
  a_cal_reverse: assert property (p_cal_reverse) else $error("cal order wrong");

  property p_quiet_hold;
    fire == 15'h0 && !preset |=> $stable(state_word(r));
  endproperty
  a_quiet_hold: assert property (p_quiet_hold) else $error("element moved");

  property p_preset;
    preset |=> att_h_sig == GAIN_PRESET && !filter_in && !uncaged && heater_relay == HEAT_PRESET;
  endproperty
  a_preset: assert property (p_preset) else $error("preset wrong");

  property p_arm_first;
    fire[LINE_UNCAGE] && !preset && !r.armed |=> !uncage_fire;
  endproperty
  a_arm_first: assert property (p_arm_first) else $error("fired unarmed");

  property p_execute;
    fire[LINE_UNCAGE] && !preset && r.armed |=> uncage_fire && uncaged ##1 !uncage_fire;
  endproperty
  a_execute: assert property (p_execute) else $error("execute failed");

  property p_speed_mode;
    !level_cmd_mode |-> !level_speed_high && !level_dir_neg;
  endproperty
  a_speed_mode: assert property (p_speed_mode) else $error("speed outside command mode");

  property p_filter_toggle;
    fire[LINE_FILTER] && !preset |=> filter_in != $past(filter_in);
  endproperty
  a_filter_toggle: assert property (p_filter_toggle) else $error("filter stuck");

  property p_motor_x;
    fire[LINE_MOTOR_X] && !preset |=> motor_x_on != $past(motor_x_on);
  endproperty
  a_motor_x: assert property (p_motor_x) else $error("motor x stuck");

  property p_apb_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb timing wrong");

endmodule
`default_nettype wire

// ==== tb/seicmd_decoder_model.sv ====
// Behavioural command decoder that drives one command line at a time.
// Assumes the testbench asks for a pulse with go and waits until busy falls.
`timescale 1ns/1ps
`default_nettype none
module seicmd_decoder_model
(
  input wire logic pclk, // system clock
  input wire logic presetn, // asynchronous reset, active low
  input wire logic go, // request one pulse
  input wire logic [3:0] line, // command line to pulse
  input wire logic [7:0] hold, // high time in cycles, at least two
  output logic [14:0] cmd_pulse, // command lines, idle low
  output logic busy // pulse or its low guard time in progress
);
  logic [7:0] cnt;
  logic [1:0] low;

  // Only one line is ever high, so arm and execute arrive as separate pulses.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_pulse <= 15'h0000;
      busy <= 1'b0;
      cnt <= 8'h00;
      low <= 2'h0;
    end
    else if (!busy)
    begin
      if (go)
      begin
        busy <= 1'b1;
        cmd_pulse <= 15'h0001 << line;
        cnt <= hold;
        low <= 2'h3;
      end
    end
    else if (cnt > 8'h01)
      cnt <= cnt - 8'h01;
    else if (cmd_pulse != 15'h0000)
      cmd_pulse <= 15'h0000;
    else if (low > 2'h1)
      low <= low - 2'h1;
    else
      busy <= 1'b0;
  end
endmodule
`default_nettype wire

// ==== tb/seicmd_tb_top.sv ====
// Self-checking testbench for the seismic command termination logic.
// Assumes the package, the design and the decoder model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module seicmd_tb_top
  import seicmd_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, go, busy;
  logic [3:0] line = 4'h0;
  logic [7:0] hold = 8'h03;
  logic [14:0] cmd_pulse;
  logic [1:0] ahs, ahc, avs, avc, aps, apc, heat;
  logic filt, mode, spd, dir, coarse, mx, my, mz, clp, csp, armed, fire, uncaged;
  logic [25:0] act;
  logic [31:0] exp_st, q;
  logic e;
  int errors = 0;
  int n_checks = 0;
  int fires = 0;
  int cyc = 0;
  int seq [0:27] = '{3, 4, 2, 3, 1, 5, 6, 7, 8, 12, 13, 9, 9, 9, 9, 10, 10, 10, 10,
    11, 11, 11, 11, 14, 14, 14, 14, 2};

  initial go = 1'b0;
  always #50 pclk = ~pclk;
  assign act = {ahs, ahc, avs, avc, aps, apc, heat, filt, mode, spd, dir, coarse, mx, my, mz,
    clp, csp, armed, uncaged};

  seicmd_core seicmd_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_pulse(cmd_pulse), .att_h_sig(ahs),
    .att_h_cal(ahc), .att_v_sig(avs), .att_v_cal(avc), .att_sp_sig(aps), .att_sp_cal(apc),
    .heater_relay(heat), .filter_in(filt), .level_cmd_mode(mode), .level_speed_high(spd),
    .level_dir_neg(dir), .coarse_sensor_on(coarse), .motor_x_on(mx), .motor_y_on(my),
    .motor_z_on(mz), .cal_lp_on(clp), .cal_sp_on(csp), .uncage_armed(armed),
    .uncage_fire(fire), .uncaged(uncaged));

  seicmd_decoder_model seicmd_decoder_model_inst (.pclk(pclk), .presetn(presetn), .go(go),
    .line(line), .hold(hold), .cmd_pulse(cmd_pulse), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  // Expected outputs follow from the state word; calibration steps mirror signal steps.
  function automatic logic [25:0] outv(input logic [31:0] s);
    return {s[1:0], ~s[1:0], s[3:2], ~s[3:2], s[5:4], ~s[5:4], s[7:6], s[10], s[11],
      s[12] & s[11], s[13] & s[11], s[14], s[15], s[16], s[17], s[18], s[19], s[8], s[9]};
  endfunction

  function automatic logic [31:0] step(input logic [31:0] s, input int ln);
    logic [31:0] r;
    int b;
    r = s;
    b = (ln < 9) ? ln + 9 : ln + 6;
    case (ln)
      LINE_UNCAGE: r[ST_UNCAGED:ST_ARMED] = s[ST_UNCAGED] ? s[9:8] : {s[8], !s[8]};
      LINE_GAIN_H: r[ST_GAIN_H +: 2] = s[ST_GAIN_H +: 2] + 2'h1;
      LINE_GAIN_V: r[ST_GAIN_V +: 2] = s[ST_GAIN_V +: 2] + 2'h1;
      LINE_GAIN_SP: r[ST_GAIN_SP +: 2] = s[ST_GAIN_SP +: 2] + 2'h1;
      LINE_HEATER: r[ST_HEAT +: 2] = s[ST_HEAT +: 2] + 2'h1;
      default: r[b] = !s[b];
    endcase
    return r;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    n_checks++;
    if (got !== want)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    exp_st = {24'h0, HEAT_PRESET, GAIN_PRESET, GAIN_PRESET, GAIN_PRESET};
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends when pready is high; should it never rise, only the bench timeout ends it.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pulse one pin through the decoder model, then compare outputs and state word.
  task automatic cmd(input int ln, input logic upd);
    @(posedge pclk);
    go <= 1'b1;
    line <= 4'(ln);
    hold <= (ln == LINE_FILTER) ? 8'h14 : 8'h03;
    @(posedge pclk);
    go <= 1'b0;
    do
    begin
      @(posedge pclk);
    end
    while (busy === 1'b1);
    repeat (4) @(posedge pclk);
    if (upd)
      exp_st = step(exp_st, ln);
    chk({6'h0, act}, {6'h0, outv(exp_st)});
    apb(1'b0, ADDR_STATE, 32'h0);
    chk(q, exp_st);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    cyc++;
    if (fire === 1'b1)
      fires++;
    if (cyc == 30000)
    begin
      errors++;
      $display("Error at %0t: run did not finish in time", $time);
      report_and_stop();
    end
  end

  initial
  begin
    do_reset();
    chk({5'h0, act, fire}, {5'h0, outv(exp_st), 1'b0});
    apb(1'b0, ADDR_STATE, 32'h0);
    chk(q, exp_st);
    apb(1'b0, ADDR_MASK, 32'h0);
    chk(q, {17'h0, MASK_RESET});
    apb(1'b0, 8'h0c, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, ADDR_STATE, 32'hffff_ffff);
    apb(1'b0, ADDR_STATE, 32'h0);
    chk(q, exp_st);
    apb(1'b0, ADDR_SWCMD, 32'h0);
    chk(q, 32'h0);
    foreach (seq[i])
      cmd(seq[i], 1'b1);
    // A masked line must be ignored even though the pin pulses.
    apb(1'b1, ADDR_MASK, 32'hffff_fffe);
    apb(1'b0, ADDR_MASK, 32'h0);
    chk(q, 32'h0000_7ffe);
    cmd(LINE_UNCAGE, 1'b0);
    apb(1'b1, ADDR_MASK, 32'h0000_7fff);
    cmd(LINE_UNCAGE, 1'b1);
    chk(32'(fires), 32'h0);
    apb(1'b1, ADDR_SWCMD, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    exp_st = step(exp_st, LINE_UNCAGE);
    chk({6'h0, act}, {6'h0, outv(exp_st)});
    chk(32'(fires), 32'h1);
    cmd(LINE_UNCAGE, 1'b1);
    chk(32'(fires), 32'h1);
    // Clear the mask first so that the read after reset proves the mask preset.
    apb(1'b1, ADDR_MASK, 32'h0000_0000);
    do_reset();
    chk({6'h0, act}, {6'h0, outv(exp_st)});
    apb(1'b0, ADDR_MASK, 32'h0);
    chk(q, {17'h0, MASK_RESET});
    report_and_stop();
  end
endmodule
`default_nettype wire
